/* logic/ambient_monitor_pkg.sv */
// Purpose: shared constants and carriers for the ambient light threshold monitor
// Assumes: 32-bit APB data, one register per aligned word, index times four is the address
// Notes:   status bit n of the flags word belongs to slot (n / 4), channel (n % 4) + 1
package ambient_monitor_pkg;

    // bus geometry
    localparam int unsigned ADDR_W   = 12;            // byte address width seen by the slave
    localparam int unsigned DATA_W   = 32;            // apb data width
    localparam int unsigned STRB_W   = DATA_W / 8;    // byte strobes

    // register indices as printed; byte address is four times the index
    localparam logic [9:0] FLAGS_IDX  = 10'h004;      // background_light_flags
    localparam logic [9:0] SLOT_A_IDX = 10'h016;      // slot_a_background_threshold_cfg
    localparam logic [9:0] SLOT_B_IDX = 10'h01c;      // slot_b_background_threshold_cfg
    localparam logic [ADDR_W-1:0] FLAGS_ADDR  = {FLAGS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] SLOT_A_ADDR = {SLOT_A_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] SLOT_B_ADDR = {SLOT_B_IDX, 2'h0};

    // geometry of the monitor
    localparam int unsigned SLOTS    = 2;             // slot a and slot b
    localparam int unsigned CHANNELS = 4;             // channels per slot
    localparam int unsigned LANES    = SLOTS * CHANNELS;
    localparam int unsigned CNT_W    = 5;             // wide enough to hold sixteen
    localparam int unsigned REG_W    = 16;            // width of each configuration register

    // configuration word layout
    localparam int unsigned LIMIT_LSB  = 0;           // ambient limit, 14 bits
    localparam int unsigned LIMIT_W    = 14;
    localparam int unsigned TARGET_LSB = 14;          // exceed target code, 2 bits
    localparam int unsigned TARGET_W   = 2;

    // exceed target codes and the counts they stand for
    localparam logic [TARGET_W-1:0] TARGET_NEVER   = 2'h0;
    localparam logic [TARGET_W-1:0] TARGET_ONE     = 2'h1;
    localparam logic [TARGET_W-1:0] TARGET_FOUR    = 2'h2;
    localparam logic [TARGET_W-1:0] TARGET_SIXTEEN = 2'h3;
    localparam logic [CNT_W-1:0]    COUNT_NONE     = 5'h00;
    localparam logic [CNT_W-1:0]    COUNT_ONE      = 5'h01;
    localparam logic [CNT_W-1:0]    COUNT_FOUR     = 5'h04;
    localparam logic [CNT_W-1:0]    COUNT_SIXTEEN  = 5'h10;

    // reset values
    localparam logic [REG_W-1:0]  CFG_RESET   = 16'h0000;
    localparam logic [LANES-1:0]  FLAGS_RESET = 8'h00;

    // one adc result tagged with where it came from
    typedef struct packed {
        logic               valid;     // one-cycle strobe, result is present
        logic               slot_b;    // 0 slot a, 1 slot b
        logic [1:0]         chan;      // 0 is channel 1
        logic               subtract;  // result belongs to a float-mode subtract cycle
        logic [LIMIT_W-1:0] result;    // adc result
    } sample_t;

    // apb request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [STRB_W-1:0] pstrb;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

endpackage

/* logic/ambient_threshold_monitor.sv */
// Purpose: counts adc results above a per-slot ambient limit and raises sticky flags
// Assumes: one sample per cycle at most; apb master follows setup then access
// Notes:   zero-wait slave, pready rises in the first access cycle
//
// How it works
// - slot a subtract results above limit counted
// - slot a code picks never, 1, 4, 16
// - slot b code uses same encoding
// - slot b counts subtract results, own limit
// - slot b flags sit in bits 7:4
// - slot a flags sit in bits 3:0
// - reading flags clears slot b bits
// - reading clears slot a, flags not writable
// - slot b limit in low 14 bits
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ambient_threshold_monitor (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_b,
    input  wire ambient_monitor_pkg::apb_req_t   apb_req,
    output      ambient_monitor_pkg::apb_rsp_t   apb_rsp,
    input  wire ambient_monitor_pkg::sample_t    sample_in
);
    import ambient_monitor_pkg::*;

    // register selection codes
    typedef enum logic [1:0] {
        SEL_FLAGS  = 2'b00,
        SEL_SLOT_A = 2'b01,
        SEL_SLOT_B = 2'b10,
        SEL_NONE   = 2'b11
    } reg_sel_t;

    logic [REG_W-1:0] cfg_ff      [SLOTS];   // threshold configuration, index 0 is slot a
    logic [LANES-1:0] flags_ff;              // sticky status, lane = slot*4 + channel
    logic [CNT_W-1:0] cnt_ff      [LANES];   // exceed counters
    logic [LANES-1:0] clr_mask_ff;           // flag bits returned by the read in flight
    apb_rsp_t         rsp_ff;                // registered bus answer

    logic             setup_phase;           // first cycle of a transfer
    logic             done_phase;            // completing edge of a transfer
    reg_sel_t         sel;                   // decoded register
    logic [LANES-1:0] clr_now;               // flags cleared at this edge
    logic [LANES-1:0] hit;                   // lane counts a new exceedance
    logic [LANES-1:0] set_vec;               // lane reaches its target now
    logic [CNT_W-1:0] base   [LANES];        // counter after any restart
    logic [CNT_W-1:0] nxt_cnt [LANES];       // counter next value
    logic [CNT_W-1:0] tgt    [LANES];        // target count of each lane

    assign apb_rsp = rsp_ff;

    // target count for a 2-bit code
    function automatic logic [CNT_W-1:0] target_count(input logic [TARGET_W-1:0] code);
        logic [CNT_W-1:0] n;
        n = COUNT_NONE;
        unique case (code)
            TARGET_NEVER:   n = COUNT_NONE;
            TARGET_ONE:     n = COUNT_ONE;
            TARGET_FOUR:    n = COUNT_FOUR;
            TARGET_SIXTEEN: n = COUNT_SIXTEEN;
        endcase
        return n;
    endfunction

    // map a byte address to a register
    // addresses with low bits set fall through to the error answer
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t s;
        s = SEL_NONE;
        if (addr == FLAGS_ADDR) begin
            s = SEL_FLAGS;
        end else if (addr == SLOT_A_ADDR) begin
            s = SEL_SLOT_A;
        end else if (addr == SLOT_B_ADDR) begin
            s = SEL_SLOT_B;
        end
        return s;
    endfunction

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0]  old,
                                               input logic [DATA_W-1:0] wdata,
                                               input logic [STRB_W-1:0] strb);
        logic [REG_W-1:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction

    // bus phase decode
    always_comb begin
        setup_phase = apb_req.psel & ~apb_req.penable;
        done_phase  = apb_req.psel & apb_req.penable & rsp_ff.pready;
        sel         = decode(apb_req.paddr);
        clr_now     = done_phase ? clr_mask_ff : '0;
    end

    // per-lane compare, count and target logic
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            // slot a lanes 0..3 feed bits 3:0, slot b lanes 4..7 feed bits 7:4
            tgt[i]     = target_count(cfg_ff[i / CHANNELS][TARGET_LSB +: TARGET_W]);
            base[i]    = clr_now[i] ? COUNT_NONE : cnt_ff[i];
            hit[i]     = sample_in.valid & sample_in.subtract
                       & ({sample_in.slot_b, sample_in.chan} == 3'(i))
                       & (sample_in.result >
                          cfg_ff[i / CHANNELS][LIMIT_LSB +: LIMIT_W])
                       & (tgt[i] != COUNT_NONE)
                       & (base[i] < tgt[i]);
            nxt_cnt[i] = base[i] + CNT_W'(hit[i]);
            set_vec[i] = hit[i] & (nxt_cnt[i] == tgt[i]);
        end
    end

    // exceed counters
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < LANES; i++) begin
                cnt_ff[i] <= COUNT_NONE;
            end
        end else begin
            for (int i = 0; i < LANES; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end

    // sticky flags, a new set wins over the read clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            flags_ff <= (flags_ff & ~clr_now) | set_vec;
        end
    end

    // configuration writes at the completing edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff[0] <= CFG_RESET;
            cfg_ff[1] <= CFG_RESET;
        end else if (done_phase & apb_req.pwrite) begin
            if (sel == SEL_SLOT_A) begin
                cfg_ff[0] <= merge(cfg_ff[0], apb_req.pwdata, apb_req.pstrb);
            end
            if (sel == SEL_SLOT_B) begin
                cfg_ff[1] <= merge(cfg_ff[1], apb_req.pwdata, apb_req.pstrb);
            end
        end
    end

    // which flag bits the pending read returned
    // a flag set between setup and completion was not returned, so it survives
    // the clear and is seen by the next read
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_mask_ff <= FLAGS_RESET;
        end else if (setup_phase) begin
            // only a read of the flags word clears anything
            clr_mask_ff <= (!apb_req.pwrite && sel == SEL_FLAGS) ? flags_ff : '0;
        end else if (done_phase) begin
            clr_mask_ff <= '0;
        end
    end

    // bus answer, captured at setup so it is ready in the access cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.pready  <= setup_phase;
            rsp_ff.pslverr <= setup_phase & (sel == SEL_NONE);
            // read data stands only in the access cycle, zero at every other edge
            rsp_ff.prdata  <= '0;
            if (setup_phase && !apb_req.pwrite) begin
                unique case (sel)
                    SEL_FLAGS:  rsp_ff.prdata <= DATA_W'(flags_ff);
                    SEL_SLOT_A: rsp_ff.prdata <= DATA_W'(cfg_ff[0]);
                    SEL_SLOT_B: rsp_ff.prdata <= DATA_W'(cfg_ff[1]);
                    SEL_NONE:   rsp_ff.prdata <= '0;
                endcase
            end
        end
    end

    // ready follows setup by one cycle
    ready_after_setup_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        setup_phase |=> rsp_ff.pready && !$past(rsp_ff.pready))
        else $error("pready did not follow setup");

    // ready drops after a completed transfer
    ready_one_cycle_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        done_phase |=> !rsp_ff.pready)
        else $error("pready stayed high after completion");

    // unmapped address gives an error answer
    unmapped_error_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        setup_phase && sel == SEL_NONE |=> rsp_ff.pslverr && rsp_ff.prdata == '0)
        else $error("unmapped access not flagged");

    // a read returns the flags held before clearing
    flags_readback_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        setup_phase && !apb_req.pwrite && sel == SEL_FLAGS
        |=> rsp_ff.prdata == DATA_W'($past(flags_ff)))
        else $error("flags read did not return held value");

    // completed read clears the returned bits unless newly set
    read_clears_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        done_phase && clr_mask_ff != '0
        |=> (flags_ff & $past(clr_mask_ff) & ~$past(set_vec)) == '0)
        else $error("read did not clear flags");

    // a write to the flags word changes nothing but new sets
    flags_no_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        done_phase && apb_req.pwrite && sel == SEL_FLAGS
        |=> flags_ff == ($past(flags_ff) | $past(set_vec)))
        else $error("flags word was written");

    // slot a flags never rise with code never
    slot_a_never_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (flags_ff[3:0] & ~$past(flags_ff[3:0])) != 4'h0
        |-> $past(cfg_ff[0][TARGET_LSB +: TARGET_W]) != TARGET_NEVER)
        else $error("slot a flag rose with target never");

    // slot b flags never rise with code never
    slot_b_never_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (flags_ff[7:4] & ~$past(flags_ff[7:4])) != 4'h0
        |-> $past(cfg_ff[1][TARGET_LSB +: TARGET_W]) != TARGET_NEVER)
        else $error("slot b flag rose with target never");

    // the flags word reads zero above the eight status bits
    flags_upper_zero_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        setup_phase && !apb_req.pwrite && sel == SEL_FLAGS
        |=> rsp_ff.prdata[DATA_W-1:LANES] == '0)
        else $error("flags word has bits above the status field");

    // a full slot a write lands at the completing edge
    slot_a_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        done_phase && apb_req.pwrite && sel == SEL_SLOT_A && apb_req.pstrb[1:0] == 2'h3
        |=> cfg_ff[0] == $past(apb_req.pwdata[REG_W-1:0]))
        else $error("slot a configuration write did not land");

    // a full slot b write lands at the completing edge, upper half ignored
    slot_b_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        done_phase && apb_req.pwrite && sel == SEL_SLOT_B && apb_req.pstrb[1:0] == 2'h3
        |=> cfg_ff[1] == $past(apb_req.pwdata[REG_W-1:0]))
        else $error("slot b configuration write did not land");

    // per-lane checks on counter and flag
    for (genvar g = 0; g < LANES; g++) begin : lane_chk
        // a flag rises only when the counter reached its target
        flag_at_target_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            $rose(flags_ff[g]) |-> cnt_ff[g] == $past(tgt[g]))
            else $error("flag rose before target reached");

        // a counter step needs a subtract result above the limit
        count_step_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            cnt_ff[g] != COUNT_NONE && cnt_ff[g] != $past(cnt_ff[g])
            |-> $past(sample_in.valid) && $past(sample_in.subtract)
                && $past(sample_in.result) > $past(cfg_ff[g / CHANNELS][LIMIT_LSB +: LIMIT_W]))
            else $error("counter moved without an exceedance");

        // a counter at target sets its flag at once
        set_flag_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            set_vec[g] |=> flags_ff[g] && cnt_ff[g] == $past(tgt[g]))
            else $error("target reached but flag not set");

        // a counter at or above its target holds until its flag is cleared
        // lowering the target to or below the count freezes the counter rather than flagging
        count_hold_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            cnt_ff[g] >= tgt[g] && !clr_now[g]
            |=> cnt_ff[g] == $past(cnt_ff[g]))
            else $error("counter moved past its target");

        // a cleared flag restarts its counter, a hit at that edge counts once
        count_restart_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            clr_now[g] |=> cnt_ff[g] <= COUNT_ONE)
            else $error("counter did not restart after clear");

        // only results tagged with this slot and channel move its counter
        lane_route_a: assert property (
            @(posedge sys_clk) disable iff (!rst_b)
            cnt_ff[g] != COUNT_NONE && cnt_ff[g] != $past(cnt_ff[g])
            |-> $past({sample_in.slot_b, sample_in.chan}) == 3'(g))
            else $error("counter moved for another lane");
    end

endmodule

/* test/test_background_light_threshold_monitor.sv */
// Purpose: self-checking bench for the ambient light threshold monitor
// Assumes: zero-wait apb slave, one adc sample strobe per cycle
// Notes:   every slot and target code is walked; flags are read-to-clear
`timescale 1ns/1ps
module test_background_light_threshold_monitor;
    import ambient_monitor_pkg::*;

    logic     sys_clk;    // 40 MHz bench clock
    logic     rst_b;      // async reset, active low
    apb_req_t apb_req;    // apb request driven by the bench
    apb_rsp_t apb_rsp;    // apb answer from the design
    sample_t  sample_in;  // adc result stream
    int       failures;   // mismatches seen
    int       tests_run;  // comparisons made

    ambient_threshold_monitor DUT (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .apb_req   (apb_req),
        .apb_rsp   (apb_rsp),
        .sample_in (sample_in)
    );

    // clock, 25 ns period
    always #12.5 sys_clk = ~sys_clk;

    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge sys_clk);
        apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:wd, pstrb:4'hf};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        if (n >= 50) begin
            failures++;
            $display("Error at %0t: no pready seen %h expected %h", $time, n, 1);
        end
        apb_req <= '0;
    endtask

    // register write, ignoring the answer
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, wd, rd, er);
    endtask

    // register read returning data and error flag
    task automatic rd_raw(input logic [11:0] a, output logic [31:0] rd, output logic er);
        apb(1'b0, a, 32'h0000_0000, rd, er);
    endtask

    // register read compared with expectation, no error allowed
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        er;
        rd_raw(a, rd, er);
        check(rd, exp);
        check({31'h0, er}, 32'h0000_0000);
    endtask

    // one adc result strobe lasting a single cycle
    task automatic hit(input logic s, input logic [1:0] c, input logic [13:0] r,
                       input logic sub);
        @(posedge sys_clk);
        sample_in <= '{valid:1'b1, slot_b:s, chan:c, subtract:sub, result:r};
        @(posedge sys_clk);
        sample_in.valid <= 1'b0;
    endtask

    // a run of counted hits just above the limit
    task automatic hits(input logic s, input logic [1:0] c, input logic [13:0] lim,
                        input int n);
        for (int i = 0; i < n; i++) begin
            hit(s, c, lim + 14'h0001, 1'b1);
        end
    endtask

    // closing report and verdict
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run length
    initial begin
        #(25 * 40000);
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        logic [31:0] rd;
        logic        er;
        logic [11:0] cfg_addr;
        logic [13:0] lim;
        logic [31:0] bit_exp;
        int          n;
        sys_clk   = 1'b0;
        rst_b     = 1'b0;
        apb_req   = '0;
        sample_in = '0;
        failures  = 0;
        tests_run = 0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        // reset values of all three registers
        rd_chk(FLAGS_ADDR, 32'h0000_0000);
        rd_chk(SLOT_A_ADDR, 32'h0000_0000);
        rd_chk(SLOT_B_ADDR, 32'h0000_0000);
        // every slot, every target code, each code on its own channel
        for (int s = 0; s < 2; s++) begin
            for (int code = 0; code < 4; code++) begin
                cfg_addr = (s == 1) ? SLOT_B_ADDR : SLOT_A_ADDR;
                lim      = (s == 1) ? 14'h3ffe : 14'h0100;
                n        = (code == 1) ? 1 : (code == 2) ? 4 : 16;
                bit_exp  = (code == 0) ? 32'h0 : (32'h1 << (s * 4 + code));
                wr(cfg_addr, {16'hffff, code[1:0], lim});
                rd_chk(cfg_addr, {16'h0, code[1:0], lim});
                // equal to limit and non-subtract results are not counted
                hit(s[0], code[1:0], lim, 1'b1);
                hit(s[0], code[1:0], lim + 14'h0001, 1'b0);
                hits(s[0], code[1:0], lim, n - 1);
                rd_chk(FLAGS_ADDR, 32'h0000_0000);
                hits(s[0], code[1:0], lim, 1);
                rd_chk(FLAGS_ADDR, bit_exp);
                rd_chk(FLAGS_ADDR, 32'h0000_0000);
                if (code == 2) begin
                    // counter restarts from zero after the flag is cleared
                    hits(s[0], code[1:0], lim, 3);
                    rd_chk(FLAGS_ADDR, 32'h0000_0000);
                    hits(s[0], code[1:0], lim, 1);
                    rd_chk(FLAGS_ADDR, bit_exp);
                    // a second lane of the same slot counts and flags on its own
                    hits(s[0], 2'h0, lim, 4);
                    rd_chk(FLAGS_ADDR, 32'h1 << (s * 4));
                end
                wr(cfg_addr, 32'h0000_0000);
            end
        end
        // flags are not writable
        wr(FLAGS_ADDR, 32'h0000_00ff);
        rd_chk(FLAGS_ADDR, 32'h0000_0000);
        // unmapped address answers with an error and zero data
        rd_raw(12'h3fc, rd, er);
        check(rd, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
        give_verdict();
    end
endmodule
